// ### shared/fvc_pkg.sv
`default_nettype none
package fvc_pkg;
  // reset values of both registers
  localparam logic [7:0] TUNE_RST = 8'hfb;
  localparam logic [7:0] PIN_RST  = 8'hdf;
  // reserved bits forced to zero on every load
  localparam logic [7:0] TUNE_KEEP = 8'hfb;
  localparam logic [7:0] PIN_KEEP  = 8'hdf;
  // instruction codes of the register access commands
  localparam logic [7:0] CMD_WR_TUNE = 8'h81;
  localparam logic [7:0] CMD_RD_TUNE = 8'h85;
  localparam logic [7:0] CMD_WR_PIN  = 8'h61;
  localparam logic [7:0] CMD_RD_PIN  = 8'h65;
  // dummy count used when the field holds zero
  localparam logic [3:0] DUMMY_ZERO_AS = 4'hf;
  // wrap field encodings
  localparam logic [1:0] WRAP_16  = 2'h0;
  localparam logic [1:0] WRAP_32  = 2'h1;
  localparam logic [1:0] WRAP_64  = 2'h2;
  localparam logic [1:0] WRAP_SEQ = 2'h3;
  // drive strength codes and their impedance in ohms
  localparam logic [2:0] DRV_90 = 3'h1;
  localparam logic [2:0] DRV_60 = 3'h2;
  localparam logic [2:0] DRV_45 = 3'h3;
  localparam logic [2:0] DRV_20 = 3'h5;
  localparam logic [2:0] DRV_15 = 3'h6;
  localparam logic [2:0] DRV_30 = 3'h7;
  localparam logic [6:0] OHM_90 = 7'h5a;
  localparam logic [6:0] OHM_60 = 7'h3c;
  localparam logic [6:0] OHM_45 = 7'h2d;
  localparam logic [6:0] OHM_20 = 7'h14;
  localparam logic [6:0] OHM_15 = 7'h0f;
  localparam logic [6:0] OHM_30 = 7'h1e;
  localparam int         ADDR_W = 24;

  typedef enum logic [1:0] {
    PROTO_EXT,
    PROTO_DUAL,
    PROTO_QUAD
  } fvc_proto_t;

  typedef struct packed {
    logic [3:0] dummy;
    logic       xipOff;
    logic       rsvd;
    logic [1:0] wrap;
  } fvc_tune_t;

  typedef struct packed {
    logic       quadOff;
    logic       dualOff;
    logic       rsvd;
    logic       holdOn;
    logic       accelOff;
    logic [2:0] drive;
  } fvc_pin_t;
endpackage : fvc_pkg
`default_nettype wire

// ### src/fvc_config_regs.sv
`default_nettype none
// Contract
// - tune bits 7:4 give fast read dummy clocks
// - execute in place only while bit 3 clear
// - basic variant ignores the arm bit
// - wrap field applies to every read
// - wrap walks to block end then start
// - wrap codes 16/32/64/sequential, default sequential
// - dummy zero behaves as fifteen, default fifteen
// - register changes only on its write command
// - pin bit 7 low selects quad protocol
// - bit 7 high falls back to dual/extended
// - bit 6 low with bit 7 high: dual
// - quad wins over dual when both low
// - pin bit 4 low disables hold/reset
// - power-on hold enable follows persistent bit 4
// - accelerator bit counts only for quad use
// - bits 2:0 decode output drive strength
module fvc_config_regs (
  input  wire logic               ref_clk,       // system clock
  input  wire logic               rst_n,         // power-on reset
  input  wire fvc_pkg::fvc_tune_t persistTune,   // power-on tune value
  input  wire fvc_pkg::fvc_pin_t  persistPin,    // power-on pin value
  input  wire logic               basicXip,      // basic xip variant strap
  input  wire logic               spiSelN,       // chip select pin
  input  wire logic               spiClk,        // serial clock pin
  input  wire logic [3:0]         dqIn,          // data lines in
  output logic      [3:0]         dqOut,         // data lines out
  output logic      [3:0]         dqOe,          // data line enables
  input  wire logic               rdStart,       // load read start address
  input  wire logic [23:0]        rdAddr,        // issued read address
  input  wire logic               rdStep,        // advance one byte
  output logic      [23:0]        curAddr,       // byte address now read
  input  wire logic               quadProgCmd,   // quad fast program running
  output logic      [3:0]         dummyClocks,   // dummy clocks in effect
  output logic                    xipAllowed,    // xip may be entered
  output fvc_pkg::fvc_proto_t     protocol,      // command protocol
  output logic                    holdEnable,    // hold/reset pin active
  output logic                    accelEnable,   // accelerator pin honoured
  output logic      [6:0]         driveOhms,     // drive impedance
  output logic                    driveReserved  // drive code reserved
);
  import fvc_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_OPCODE,
    ST_DATA,
    ST_READ,
    ST_IGNORE
  } fvc_state_t;

  fvc_tune_t  tune;
  fvc_pin_t   pinCfg;
  fvc_state_t state;
  logic       loaded;
  logic [1:0] csSync;
  logic [1:0] clkSync;
  logic [7:0] dqSync;
  logic       csPrev;
  logic       clkPrev;
  logic [7:0] shiftIn;
  logic [3:0] bitCnt;
  logic [7:0] opcode;
  logic       dataDone;
  logic [7:0] shiftOut;
  logic [3:0] lanes;
  logic       holdActive;
  logic       clkRise;
  logic       clkFall;
  logic       csRise;
  logic       csFall;
  logic [7:0] next_shift;
  logic [3:0] next_cnt;

  // lanes carrying bits in each protocol
  function automatic logic [3:0] laneCount(input fvc_proto_t p);
    case (p)
      PROTO_QUAD: laneCount = 4'h4;
      PROTO_DUAL: laneCount = 4'h2;
      default:    laneCount = 4'h1;
    endcase
  endfunction : laneCount

  // shift the sampled lines into a byte, msb first
  function automatic logic [7:0] shiftBits(input logic [7:0] sr,
                                           input logic [3:0] dq,
                                           input fvc_proto_t p);
    case (p)
      PROTO_QUAD: shiftBits = {sr[3:0], dq};
      PROTO_DUAL: shiftBits = {sr[5:0], dq[1:0]};
      default:    shiftBits = {sr[6:0], dq[0]};
    endcase
  endfunction : shiftBits

  // next byte address under the wrap setting
  function automatic logic [23:0] wrapNext(input logic [23:0] a,
                                           input logic [1:0]  w);
    logic [23:0] inc;
    inc = a + 24'h000001;
    case (w)
      WRAP_16: wrapNext = {a[23:4], inc[3:0]};
      WRAP_32: wrapNext = {a[23:5], inc[4:0]};
      WRAP_64: wrapNext = {a[23:6], inc[5:0]};
      default: wrapNext = inc;
    endcase
  endfunction : wrapNext

  // pin synchronisers; first stage feeds only the second
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      csSync  <= 2'h3;
      clkSync <= 2'h0;
      dqSync  <= 8'hff;
    end else begin
      csSync  <= {csSync[0], spiSelN};
      clkSync <= {clkSync[0], spiClk};
      dqSync  <= {dqSync[3:0], dqIn};
    end
  end

  // edge history taken from the second stage only
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      csPrev  <= 1'b1;
      clkPrev <= 1'b0;
    end else begin
      csPrev  <= csSync[1];
      clkPrev <= clkSync[1];
    end
  end

  // hold ignored in quad, where dq3 is a data lane
  // hold freezes the serial clock unless dq3 carries data
  assign holdActive = holdEnable && (protocol != PROTO_QUAD)
                      && !dqSync[7] && !csSync[1];
  assign clkRise = clkSync[1] && !clkPrev && !holdActive;
  assign clkFall = !clkSync[1] && clkPrev && !holdActive;
  assign csFall  = !csSync[1] && csPrev;
  assign csRise  = csSync[1] && !csPrev;
  assign lanes   = laneCount(protocol);
  assign next_shift = shiftBits(shiftIn, dqSync[7:4], protocol);
  assign next_cnt   = bitCnt + lanes;

  // short or long frames leave dataDone low and write nothing
  // frame decoder: opcode byte then optional data byte
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state    <= ST_IDLE;
      shiftIn  <= 8'h00;
      bitCnt   <= 4'h0;
      opcode   <= 8'h00;
      dataDone <= 1'b0;
    end else if (csSync[1]) begin
      state  <= ST_IDLE;
      bitCnt <= 4'h0;
    end else if (csFall) begin
      state    <= ST_OPCODE;
      bitCnt   <= 4'h0;
      dataDone <= 1'b0;
    end else if (clkRise) begin
      shiftIn <= next_shift;
      bitCnt  <= (next_cnt == 4'h8) ? 4'h0 : next_cnt;
      case (state)
        ST_OPCODE: begin
          if (next_cnt == 4'h8) begin
            opcode <= next_shift;
            if (next_shift == CMD_WR_TUNE ||
                next_shift == CMD_WR_PIN)
              state <= ST_DATA;
            else if (next_shift == CMD_RD_TUNE ||
                     next_shift == CMD_RD_PIN)
              state <= ST_READ;
            else
              state <= ST_IGNORE;
          end
        end
        ST_DATA: begin
          if (next_cnt == 4'h8) begin
            dataDone <= 1'b1;
            state    <= ST_IGNORE;
          end
        end
        ST_READ:   state <= ST_READ;
        ST_IGNORE: begin
          dataDone <= 1'b0;                             // extra bits void it
          state    <= ST_IGNORE;
        end
        default:   state <= ST_IDLE;
      endcase
    end
  end

  // read answer: register repeats while the clock runs
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      shiftOut <= 8'h00;
      dqOut    <= 4'h0;
      dqOe     <= 4'h0;
    end else if (csSync[1]) begin
      dqOe <= 4'h0;
    end else if (clkRise && state == ST_OPCODE && next_cnt == 4'h8) begin
      shiftOut <= (next_shift == CMD_RD_PIN) ? 8'(pinCfg) : 8'(tune);
    end else if (clkFall && state == ST_READ) begin
      case (protocol)
        PROTO_QUAD: begin
          dqOut    <= shiftOut[7:4];
          dqOe     <= 4'hf;
          shiftOut <= {shiftOut[3:0], shiftOut[7:4]};
        end
        PROTO_DUAL: begin
          dqOut    <= {2'h0, shiftOut[7:6]};
          dqOe     <= 4'h3;
          shiftOut <= {shiftOut[5:0], shiftOut[7:6]};
        end
        default: begin
          dqOut    <= {2'h0, shiftOut[7], 1'b0};
          dqOe     <= 4'h2;
          shiftOut <= {shiftOut[6:0], shiftOut[7]};
        end
      endcase
    end
  end

  // tune register: persistent load once, then only by its write
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      tune <= TUNE_RST;
    end else if (!loaded) begin
      tune <= persistTune & TUNE_KEEP;
    end else if (csRise && dataDone && opcode == CMD_WR_TUNE) begin
      tune <= shiftIn & TUNE_KEEP;
    end
  end

  // pin register: bit 5 never stored as one
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pinCfg <= PIN_RST;
    end else if (!loaded) begin
      pinCfg <= persistPin & PIN_KEEP;
    end else if (csRise && dataDone && opcode == CMD_WR_PIN) begin
      pinCfg <= shiftIn & PIN_KEEP;
    end
  end

  // rst_n doubles as power-on, so a write never survives it
  // one-shot copy of persistent values after reset release
  always_ff @(posedge ref_clk) begin
    if (!rst_n)
      loaded <= 1'b0;
    else
      loaded <= 1'b1;
  end

  // wrapped read address, held inside the aligned block for the 16/32/64 wrap codes
  always_ff @(posedge ref_clk) begin
    if (!rst_n)
      curAddr <= 24'h000000;
    else if (rdStart)
      curAddr <= rdAddr;
    else if (rdStep)
      curAddr <= wrapNext(curAddr, tune.wrap);
  end

  // decoded configuration seen by the rest of the flash
  always_comb begin
    dummyClocks = (tune.dummy == 4'h0) ? DUMMY_ZERO_AS
                                       : tune.dummy;
    xipAllowed  = basicXip || !tune.xipOff;
    if (!pinCfg.quadOff)
      protocol = PROTO_QUAD;
    else if (!pinCfg.dualOff)
      protocol = PROTO_DUAL;
    else
      protocol = PROTO_EXT;
    holdEnable  = pinCfg.holdOn;
    accelEnable = !pinCfg.accelOff &&
                  (quadProgCmd || !pinCfg.quadOff);
  end

  // reserved codes keep the default impedance rather than guess
  // drive strength decode; reserved codes flagged
  always_comb begin
    driveReserved = 1'b0;
    case (pinCfg.drive)
      DRV_90:  driveOhms = OHM_90;
      DRV_60:  driveOhms = OHM_60;
      DRV_45:  driveOhms = OHM_45;
      DRV_20:  driveOhms = OHM_20;
      DRV_15:  driveOhms = OHM_15;
      DRV_30:  driveOhms = OHM_30;
      default: begin
        driveOhms     = OHM_30;                         // keep safe drive
        driveReserved = 1'b1;
      end
    endcase
  end
endmodule : fvc_config_regs
`default_nettype wire

// ### verif/fvc_config_regs_sva.sv
`default_nettype none
module fvc_config_regs_sva
  import fvc_pkg::*;
(
  input wire logic         ref_clk,       // system clock
  input wire logic         rst_n,         // reset, active low
  input wire logic         basicXip,      // basic variant strap
  input wire logic         spiSelN,       // chip select
  input wire logic         rdStart,       // load read address
  input wire logic [23:0]  rdAddr,        // issued read address
  input wire logic         rdStep,        // advance one byte
  input wire logic [23:0]  curAddr,       // current byte address
  input wire logic         quadProgCmd,   // quad program running
  input wire logic [3:0]   dummyClocks,   // dummy clocks in effect
  input wire logic         xipAllowed,    // xip permitted
  input wire fvc_proto_t   protocol,      // command protocol
  input wire logic         holdEnable,    // hold pin active
  input wire logic         accelEnable,   // accelerator honoured
  input wire logic [6:0]   driveOhms,     // drive impedance
  input wire logic         driveReserved  // reserved drive code
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // reset defaults, checked one cycle after each cycle with reset low
  chk_reset_defaults: assert property (disable iff (1'b0) !rst_n |=>
    dummyClocks == 4'hf && protocol == PROTO_EXT)
    else $error("reset defaults wrong");
  chk_dummy_nonzero: assert property (dummyClocks != 4'h0)
    else $error("dummy count zero");
  chk_basic_xip: assert property (basicXip |-> xipAllowed)
    else $error("basic variant blocks xip");
  chk_accel_gate: assert property (accelEnable |->
    quadProgCmd || protocol == PROTO_QUAD)
    else $error("accelerator outside quad use");
  chk_drive_rsvd: assert property (
    driveReserved |-> driveOhms == OHM_30)
    else $error("reserved drive not thirty ohms");
  chk_addr_load: assert property (rdStart |=> curAddr == $past(rdAddr))
    else $error("start address not loaded");
  // every wrap size keeps the low nibble counting by one
  chk_addr_step: assert property (rdStep && !rdStart |=>
    curAddr[3:0] == $past(curAddr[3:0]) + 4'h1)
    else $error("address step wrong");
  // config only moves once the write frame has ended
  chk_cfg_frame: assert property (
    !spiSelN [*8] |-> $stable(protocol) &&
    $stable(holdEnable) && $stable(dummyClocks))
    else $error("config changed inside frame");
endmodule : fvc_config_regs_sva
bind fvc_config_regs fvc_config_regs_sva chk (.ref_clk(ref_clk),
  .rst_n(rst_n), .basicXip(basicXip), .spiSelN(spiSelN),
  .rdStart(rdStart), .rdAddr(rdAddr), .rdStep(rdStep), .curAddr(curAddr),
  .quadProgCmd(quadProgCmd), .dummyClocks(dummyClocks),
  .xipAllowed(xipAllowed), .protocol(protocol), .holdEnable(holdEnable),
  .accelEnable(accelEnable), .driveOhms(driveOhms),
  .driveReserved(driveReserved));
`default_nettype wire

// ### verif/fvc_spi_host.sv
`default_nettype none
module fvc_spi_host (
  input  wire logic       ref_clk, // system clock
  output logic            spiSelN, // chip select to device
  output logic            spiClk,  // serial clock, idle low
  output logic      [3:0] dqIn,    // data lines into device
  input  wire logic [3:0] dqOut    // data lines from device
);
  timeunit 1ns;
  timeprecision 100ps;
  // dq3 idles high like a pulled-up hold line
  initial begin
    spiSelN = 1'b1;
    spiClk  = 1'b0;
    dqIn    = 4'h8;
  end
  // five ref_clk per half period, margin over the three needed
  task automatic half();
    repeat (5) @(posedge ref_clk);
    #1;
  endtask : half
  // frame of nb bytes on the given lane count; reads shift in on dq1
  task automatic frame(input int lanes, input logic [7:0] op,
                       input logic [7:0] wd, input int nb,
                       output logic [7:0] rd);
    logic [15:0] sh;
    int          k;
    sh = {op, wd};
    rd = 8'h00;
    spiSelN = 1'b0;
    for (k = 0; k < nb * 8 / lanes; k++) begin
      dqIn = lanes == 4 ? sh[15:12] : lanes == 2 ? {2'b10, sh[15:14]} :
             {3'b100, sh[15]};
      sh = sh << lanes;
      half();
      if (k >= 8) rd = {rd[6:0], dqOut[1]};
      spiClk = 1'b1;
      half();
      spiClk = 1'b0;
    end
    half();
    spiSelN = 1'b1;
    dqIn = {1'b1, ~dqIn[2:0]}; // released lines show no stale value
    half();
  endtask : frame
endmodule : fvc_spi_host
`default_nettype wire

// ### verif/tb_flash_volatile_config_regs.sv
`default_nettype none
module tb_flash_volatile_config_regs;
  timeunit 1ns;
  timeprecision 100ps;
  import fvc_pkg::*;
  logic        ref_clk, rst_n, basicXip, spiSelN, spiClk, rdStart, rdStep;
  logic        quadProgCmd, xipAllowed, holdEnable, accelEnable, driveRsv;
  fvc_tune_t   persistTune;
  fvc_pin_t    persistPin;
  logic [3:0]  dqIn, dqOut, dqOe, dummyClocks;
  logic [23:0] rdAddr, curAddr, sz;
  fvc_proto_t  protocol;
  logic [6:0]  driveOhms;
  logic [7:0]  rd;
  int          bad_count, num_checks, lanes, w, i;
  logic [7:0]  pv [6] = '{8'h9f, 8'h1f, 8'h9f, 8'hdf, 8'h57, 8'hdf};
  fvc_proto_t  pp [6] = '{PROTO_DUAL, PROTO_QUAD, PROTO_DUAL, PROTO_EXT,
                          PROTO_QUAD, PROTO_EXT};
  logic [6:0]  ohm [8] = '{OHM_30, OHM_90, OHM_60, OHM_45, OHM_30, OHM_20,
                           OHM_15, OHM_30};
  fvc_config_regs DUT (.ref_clk(ref_clk), .rst_n(rst_n),
    .persistTune(persistTune), .persistPin(persistPin), .basicXip(basicXip),
    .spiSelN(spiSelN), .spiClk(spiClk), .dqIn(dqIn), .dqOut(dqOut),
    .dqOe(dqOe), .rdStart(rdStart), .rdAddr(rdAddr), .rdStep(rdStep),
    .curAddr(curAddr), .quadProgCmd(quadProgCmd), .dummyClocks(dummyClocks),
    .xipAllowed(xipAllowed), .protocol(protocol), .holdEnable(holdEnable),
    .accelEnable(accelEnable), .driveOhms(driveOhms),
    .driveReserved(driveRsv));
  fvc_spi_host host (.ref_clk(ref_clk), .spiSelN(spiSelN), .spiClk(spiClk),
    .dqIn(dqIn), .dqOut(dqOut));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] op, input logic [7:0] d);
    host.frame(lanes, op, d, 2, rd);
  endtask : wr
  // reads always in single-lane protocol
  task automatic rdreg(input logic [7:0] op, input logic [7:0] exp);
    host.frame(1, op, 8'h00, 2, rd);
    check(rd, exp);
  endtask : rdreg
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : wrap_up
  // watchdog so a stuck frame cannot hang the run
  initial begin
    repeat (60000) @(posedge ref_clk);
    bad_count++;
    wrap_up();
  end
  initial begin
    rst_n = 1'b0;
    {basicXip, rdStart, rdStep, quadProgCmd} = 4'h0;
    rdAddr = 24'h000000;
    persistTune = 8'h07;
    persistPin = 8'hef;
    lanes = 1;
    repeat (4) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    repeat (3) @(posedge ref_clk);
    #1;
    check(dummyClocks, 4'hf);
    check(xipAllowed, 1'b1);
    check(holdEnable, 1'b0);
    rdreg(CMD_RD_TUNE, 8'h03);
    rdreg(CMD_RD_PIN, 8'hcf);
    $display("test power_on done");
    // each wrap code from one start near a 64-byte block end
    for (w = 0; w < 4; w++) begin
      wr(CMD_WR_TUNE, {4'h5, 2'b10, w[1:0]});
      check(dummyClocks, 4'h5);
      check(xipAllowed, 1'b0);
      rdStart = 1'b1;
      rdAddr = 24'h00013e;
      @(posedge ref_clk) #1 rdStart = 1'b0;
      rdStep = 1'b1;
      repeat (2) @(posedge ref_clk);
      #1 rdStep = 1'b0;
      sz = (24'h000010 << w) - 24'h000001;
      check(curAddr, (24'h00013e & ~sz) | (24'h000140 & sz));
    end
    basicXip = 1'b1;
    #1 check(xipAllowed, 1'b1);
    @(posedge ref_clk) #1 basicXip = 1'b0;
    host.frame(1, CMD_WR_TUNE, 8'h00, 1, rd);
    rdreg(CMD_RD_TUNE, 8'h5b);
    $display("test tune_wrap done");
    for (i = 0; i < 6; i++) begin
      wr(CMD_WR_PIN, pv[i]);
      check(protocol, pp[i]);
      check(accelEnable, !pv[i][3] && pp[i] == PROTO_QUAD);
      lanes = pp[i] == PROTO_QUAD ? 4 : pp[i] == PROTO_DUAL ? 2 : 1;
    end
    wr(CMD_WR_PIN, 8'hc7);
    check(holdEnable, 1'b0);
    check(accelEnable, 1'b0);
    quadProgCmd = 1'b1;
    #1 check(accelEnable, 1'b1);
    @(posedge ref_clk) #1 quadProgCmd = 1'b0;
    for (i = 0; i < 8; i++) begin
      wr(CMD_WR_PIN, {5'b11010, i[2:0]});
      check(holdEnable, 1'b1);
      check({driveRsv, driveOhms}, {i == 0 || i == 4, ohm[i]});
    end
    $display("test pin_protocol done");
    wrap_up();
  end
endmodule : tb_flash_volatile_config_regs
`default_nettype wire
